// file: core/dsw_write_port.sv
// ddr burst-of-two sram core: command capture, byte-lane writes, read burst, beat fifo
`timescale 1ns/1ps
// Notes on behaviour
// - read starts only if read select is low at a true-clock edge
// - write starts only if write select is low at a true-clock edge
// - beat 0 sampled on true edge, beat 1 on the following complementary edge
// - narrow mode: lane 0 stores bits 0-8, lane 1 bits 9-17
// - narrow mode: both low writes 18 bits, both high aborts the beat
// - wide mode: four lanes each gate nine bits, any combination allowed
// - wide mode: all four low writes the full 36-bit word
// - burst address: beat 0 at supplied address, beat 1 at address plus one
// - read and write sequencing run concurrently on the true clock
module dsw_write_port (
    input wire logic clk,                                 // 125 MHz system clock
    input wire logic rst_n,                               // sync reset, active low
    input wire logic read_n,                              // read select, active low
    input wire logic write_n,                             // write select, active low
    input wire logic [dsw_pkg::ADDR_W-1:0] addr,          // burst start address
    input wire logic [dsw_pkg::DATA_W-1:0] data_in,       // write data of this beat
    input wire logic lane_enable_0_n,                     // bits 0-8 enable, active low
    input wire logic lane_enable_1_n,                     // bits 9-17 enable, active low
    input wire logic lane_enable_2_n,                     // bits 18-26 enable, active low
    input wire logic lane_enable_3_n,                     // bits 27-35 enable, active low
    input wire logic wide_mode,                           // 1 = 36-bit, 0 = 18-bit
    output logic beat_phase,                              // 0 = true edge cycle
    output logic [dsw_pkg::DATA_W-1:0] rd_data,           // read beat data
    output logic rd_valid,                                // read beat valid
    output logic wr_ready,                                // room for two beats in the previous cycle
    output logic wr_overflow                              // sticky beat-lost flag
);
    logic [dsw_pkg::DATA_W-1:0] mem [dsw_pkg::MEM_WORDS];
    logic phase_reg;
    logic wr_pend_reg;
    logic [dsw_pkg::ADDR_W-1:0] wr_addr_reg;
    logic rd_pend_reg;
    logic [dsw_pkg::ADDR_W-1:0] rd_addr_reg;
    logic [dsw_pkg::DATA_W-1:0] rd_data_reg;
    logic rd_valid_reg;
    logic wr_ready_reg;
    logic overflow_reg;
    logic true_edge;
    logic [dsw_pkg::LANES-1:0] beat_mask;
    logic beat_live;
    logic push_valid;
    logic push_ready;
    dsw_pkg::dsw_beat_t push_beat;
    dsw_pkg::dsw_beat_t pop_beat;
    logic pop_valid;
    logic pop_ready;
    logic mem_rd_en;
    logic [dsw_pkg::ADDR_W-1:0] mem_rd_addr;
    logic [dsw_pkg::FIFO_LVL_W-1:0] fifo_level;

    assign true_edge = phase_reg == dsw_pkg::PHASE_TRUE;

    // divider: alternate cycles stand for the true and complementary clock edges
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            phase_reg <= dsw_pkg::PHASE_TRUE;
        else
            phase_reg <= ~phase_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end
        else
        begin
            wr_pend_reg <= true_edge && !write_n;
            if (true_edge && !write_n)
                wr_addr_reg <= addr;
        end
    end

    // each beat judged on its own lane enables
    assign beat_mask = dsw_pkg::lane_mask({lane_enable_3_n, lane_enable_2_n,
                                           lane_enable_1_n, lane_enable_0_n}, wide_mode);
    // beat 0 on true edge, beat 1 one cycle later
    assign beat_live = (true_edge && !write_n) || (!true_edge && wr_pend_reg);
    assign push_valid = beat_live && (beat_mask != '0);

    always_comb
    begin
        push_beat.data = data_in;
        push_beat.lane_wr = beat_mask;
        // second beat at address plus one
        push_beat.addr = true_edge ? addr : wr_addr_reg + dsw_pkg::BURST_STEP;
    end

    // reads own the memory port, so the fifo absorbs writes during a read burst
    assign pop_ready = !mem_rd_en;

    dsw_fifo #(
        .WIDTH($bits(dsw_pkg::dsw_beat_t)),
        .DEPTH(dsw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_beat),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_beat),
        .level(fifo_level)
    );

    // full word when all lanes set, partial merge otherwise
    always_ff @(posedge clk)
    begin
        if (pop_valid && pop_ready)
            mem[pop_beat.addr] <= dsw_pkg::lane_merge(mem[pop_beat.addr], pop_beat.data,
                                                      pop_beat.lane_wr);
    end

    // registered: room for two beats in the previous cycle, so a beat pushed in that cycle can still split a burst accepted while ready
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ready_reg <= 1'b1;
            overflow_reg <= 1'b0;
        end
        else
        begin
            wr_ready_reg <= (fifo_level <= dsw_pkg::READY_LEVEL);
            if (push_valid && !push_ready)
                overflow_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= '0;
        end
        else
        begin
            rd_pend_reg <= true_edge && !read_n;
            if (true_edge && !read_n)
                rd_addr_reg <= addr;
        end
    end

    // read path independent of write capture
    assign mem_rd_en = (true_edge && !read_n) || rd_pend_reg;
    // read burst second word at address plus one
    assign mem_rd_addr = rd_pend_reg ? rd_addr_reg + dsw_pkg::BURST_STEP : addr;

    // read sees memory only; beats still queued in the fifo are not forwarded
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rd_valid_reg <= mem_rd_en;
            if (mem_rd_en)
                rd_data_reg <= mem[mem_rd_addr];
        end
    end

    assign beat_phase = phase_reg;
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign wr_ready = wr_ready_reg;
    assign wr_overflow = overflow_reg;
endmodule

// generic valid/ready fifo holding write beats
module dsw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,                           // system clock
    input wire logic rst_n,                         // sync reset, active low
    input wire logic in_valid,                      // entry offered
    output logic in_ready,                          // room for an entry
    input wire logic [WIDTH-1:0] in_data,           // entry
    output logic out_valid,                         // entry available
    input wire logic out_ready,                     // drain takes entry
    output logic [WIDTH-1:0] out_data,              // oldest entry
    output logic [$clog2(DEPTH+1)-1:0] level        // entries held
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = count_reg != FULL;
    assign out_valid = count_reg != '0;
    assign out_data = mem[rd_ptr_reg];
    assign level = count_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// file: core/dsw_pkg.sv
// constants, types and helpers for the byte-lane write port
package dsw_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int MEM_WORDS = 1 << ADDR_W;
    localparam int FIFO_LVL_W = 4;
    localparam logic [FIFO_LVL_W-1:0] READY_LEVEL = 4'h6;
    localparam logic PHASE_TRUE = 1'b0;
    localparam logic [LANES-1:0] NARROW_LANES = 4'h3;
    localparam logic [LANES-1:0] WIDE_LANES = 4'hF;
    localparam logic [ADDR_W-1:0] BURST_STEP = 8'h01;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] lane_wr;
    } dsw_beat_t;

    // active-high lanes to write; lanes 2 and 3 never count in narrow mode
    function automatic logic [LANES-1:0] lane_mask(input logic [LANES-1:0] lane_n,
                                                   input logic wide);
        lane_mask = ~lane_n & (wide ? WIDE_LANES : NARROW_LANES);
    endfunction

    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [LANES-1:0] mask);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++)
        begin
            if (mask[i])
                res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
        end
        lane_merge = res;
    endfunction
endpackage

// file: core/dsw_fifo.sv
// the beat fifo module is kept beside the write port, in dsw_write_port.sv

// file: testbench/dsw_monitor.sv
// checker for the write port
`timescale 1ns/1ps
module dsw_monitor (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic read_n, // read select
    input wire logic write_n, // write select
    input wire logic beat_phase, // phase
    input wire logic rd_valid, // read valid
    input wire logic wr_ready, // room
    input wire logic wr_overflow // lost beat
);
    logic rd_c;
    logic wr_c;
    assign rd_c = !read_n && !beat_phase;
    assign wr_c = !write_n && !beat_phase;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_read_burst: assert property (rd_c |=> rd_valid[*2]) else $error("no read beat");
    a_read_cause: assert property (rd_valid |-> $past(rd_c) || $past(rd_c, 2))
        else $error("stray read beat");
    a_odd_ignored: assert property (beat_phase && $past(read_n) |=> !rd_valid)
        else $error("odd phase command taken");
    a_both_ops: assert property (rd_c && wr_c |=> rd_valid ##1 rd_valid)
        else $error("write blocked read");
    a_phase_flip: assert property ($past(rst_n) |-> beat_phase != $past(beat_phase))
        else $error("phase stuck");
    a_ovf_sticky: assert property (wr_overflow |=> wr_overflow) else $error("flag lost");
    a_ovf_cause: assert property ($rose(wr_overflow) |-> $past(wr_c) || $past(wr_c, 2)
        || $past(wr_c, 3)) else $error("overflow without write");
    a_ready_cause: assert property ($fell(wr_ready) |-> $past(wr_c) || $past(wr_c, 2)
        || $past(wr_c, 3)) else $error("ready fell without write");
endmodule
bind dsw_write_port dsw_monitor u_mon (.clk(clk), .rst_n(rst_n), .read_n(read_n),
    .write_n(write_n), .beat_phase(beat_phase), .rd_valid(rd_valid), .wr_ready(wr_ready),
    .wr_overflow(wr_overflow));

// file: testbench/dsw_ctrl_model.sv
// controller model driving bursts on the true phase
`timescale 1ns/1ps
module dsw_ctrl_model (
    input wire logic clk, // clock
    input wire logic beat_phase, // phase
    input wire logic [35:0] rd_data, // read word
    output logic read_n = 1'b1, // read select
    output logic write_n = 1'b1, // write select
    output logic [7:0] addr = 8'h00, // address
    output logic [35:0] data_in = 36'h0, // beat data
    output logic [3:0] lane_n = 4'hF // lane enables
);
    logic [35:0] q0;
    logic [35:0] q1;
    // data flips when released so a stale beat never looks valid
    task automatic idle(input int n);
        lane_n = 4'hF;
        data_in = ~data_in;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // selects low only at true edge
    task automatic burst(input logic rd, wr, input logic [7:0] a, input logic [35:0] d,
                         input logic [3:0] l0, l1);
        while (beat_phase)
        begin
            @(posedge clk);
            #1;
        end
        {read_n, write_n, addr, data_in, lane_n} = {!rd, !wr, a, d, l0};
        @(posedge clk);
        #1;
        {read_n, write_n, addr, data_in, lane_n} = {2'b11, ~a, ~d, l1};
        q0 = rd_data;
        @(posedge clk);
        #1;
        q1 = rd_data;
    endtask
    task automatic stray(input logic [7:0] a, input logic [35:0] d);
        while (!beat_phase)
        begin
            @(posedge clk);
            #1;
        end
        {read_n, write_n, addr, data_in, lane_n} = {2'b00, a, d, 4'h0};
        @(posedge clk);
        #1;
        {read_n, write_n, lane_n} = 6'h3F;
    endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the write port
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic w; logic [7:0] a; logic [3:0] l0, l1;
        logic [35:0] e0, e1;} dsw_row_t;
    localparam logic [35:0] ONES = 36'hF_FFFF_FFFF;
    logic clk, rst_n, wide_mode, read_n, write_n, beat_phase, rd_valid, wr_ready, wr_overflow;
    logic [7:0] addr;
    logic [35:0] data_in, rd_data;
    logic [3:0] lane_n;
    int err_count = 0;
    int samples_checked = 0;
    // prefill leaves addr at zero and addr+1 at ones; test beat 0 writes ones, beat 1 zeros
    dsw_row_t rows [5] = '{'{1'b1, 8'h10, 4'hE, 4'h0, 36'h0_0000_01FF, 36'h0},
        '{1'b1, 8'h20, 4'hD, 4'hB, 36'h0_0003_FE00, 36'hF_F803_FFFF},
        '{1'b1, 8'h30, 4'h7, 4'hF, 36'hF_F800_0000, ONES},
        '{1'b0, 8'hFF, 4'h0, 4'hE, 36'h0_0003_FFFF, 36'hF_FFFF_FE00},
        '{1'b0, 8'h50, 4'hF, 4'hD, 36'h0, 36'hF_FFFC_01FF}};
    dsw_write_port u_dut (.clk(clk), .rst_n(rst_n), .read_n(read_n), .write_n(write_n),
        .addr(addr), .data_in(data_in), .lane_enable_0_n(lane_n[0]), .lane_enable_1_n(lane_n[1]),
        .lane_enable_2_n(lane_n[2]), .lane_enable_3_n(lane_n[3]), .wide_mode(wide_mode),
        .beat_phase(beat_phase), .rd_data(rd_data), .rd_valid(rd_valid), .wr_ready(wr_ready),
        .wr_overflow(wr_overflow));
    dsw_ctrl_model u_ctl (.clk(clk), .beat_phase(beat_phase), .rd_data(rd_data),
        .read_n(read_n), .write_n(write_n), .addr(addr), .data_in(data_in), .lane_n(lane_n));
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial
    begin
        rst_n = 1'b0;
        wide_mode = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        chk({32'h0, beat_phase, rd_valid, wr_ready, wr_overflow}, 36'h2);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            wide_mode = 1'b1;
            u_ctl.burst(1'b0, 1'b1, rows[i].a, 36'h0, 4'h0, 4'h0);
            wide_mode = rows[i].w;
            u_ctl.burst(1'b0, 1'b1, rows[i].a, ONES, rows[i].l0, rows[i].l1);
            u_ctl.idle(4);
            u_ctl.burst(1'b1, 1'b0, rows[i].a, ONES, 4'hF, 4'hF);
            chk(u_ctl.q0, rows[i].e0);
            chk(u_ctl.q1, rows[i].e1);
            $display("row %0d done", i);
        end
        wide_mode = 1'b1;
        u_ctl.burst(1'b0, 1'b1, 8'h60, ONES, 4'h0, 4'h0);
        u_ctl.idle(4);
        u_ctl.burst(1'b1, 1'b1, 8'h60, 36'h0, 4'h0, 4'hF);
        chk(u_ctl.q0, ONES);
        // a write of ones on the complementary phase must not land at 8'h60
        u_ctl.stray(8'h60, ONES);
        u_ctl.idle(4);
        u_ctl.burst(1'b1, 1'b0, 8'h60, ONES, 4'hF, 4'hF);
        chk(u_ctl.q0, 36'h0);
        chk(u_ctl.q1, 36'h0);
        $display("read beside write done");
        for (int i = 0; i < 6; i++)
            u_ctl.burst(1'b1, 1'b1, 8'h70, ONES, 4'h0, 4'h0);
        chk({35'h0, wr_overflow}, 36'h1);
        chk({35'h0, wr_ready}, 36'h0);
        u_ctl.idle(12);
        chk({35'h0, wr_ready}, 36'h1);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk({35'h0, wr_overflow}, 36'h0);
        $display("overflow and reset done");
        wrap_up();
    end
endmodule
